/* dhb_pkg.sv */
// shared constants and types for the display host bus controller
package dhb_pkg;
  // protocol-select codes presented on protocol_select_1/0
  localparam logic [1:0] SEL_ENABLE_STROBE = 2'h3;
  localparam logic [1:0] SEL_SPLIT_STROBE = 2'h2;
  localparam logic [1:0] SEL_SERIAL = 2'h0;
  localparam int CLK_PERIOD_NS = 4;
  // bus timing in ns
  localparam int T_CYCLE_NS = 300;
  localparam int T_SETUP_NS = 10;
  localparam int T_RD_LOW_NS = 150;
  localparam int T_WR_LOW_NS = 60;
  localparam int T_HIGH_NS = 60;
  localparam int T_HOLD_NS = 20;
  localparam int T_SCK_HALF_NS = 50;
  // least times round up to whole cycles
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LOW_CYC =
    (T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC =
    (T_WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC =
    (T_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;
  localparam int BYTE_W = 8;
  localparam int BIT_W = 3;
  // data bus bit positions used in serial mode
  localparam int SER_CLK_BIT = 0;
  localparam int SER_DATA_BIT = 1;
  typedef enum logic [1:0] {
    DHB_MODE_ENABLE,
    DHB_MODE_SPLIT,
    DHB_MODE_SERIAL
  } dhb_mode_t;
endpackage

/* dhb_tick.sv */
// down-counting phase timer giving a one-cycle done pulse
`timescale 1ns/1ps
module dhb_tick (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [dhb_pkg::TIMER_W-1:0] count_in,
  output logic done_out
);
  typedef struct packed {
    logic [dhb_pkg::TIMER_W-1:0] cnt;
    logic run;
    logic done;
  } dhb_tick_st_t;
  dhb_tick_st_t st_reg;
  dhb_tick_st_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load_in) begin
      st_next.cnt = count_in;
      st_next.run = 1'b1;
    end else if (st_reg.run) begin
      if (st_reg.cnt <= dhb_pkg::TIMER_W'(1)) begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - dhb_pkg::TIMER_W'(1);
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign done_out = st_reg.done;
endmodule

/* dhb_host.sv */
// host controller driving the display bus port in any of three modes
// What this block does
// - enable-strobe mode: enable pin high with chip select low starts transfer.
// - enable-strobe mode: direction pin high for read, low for write.
// - split-strobe mode: read strobe low with chip select low reads data.
// - split-strobe mode: write strobe low with chip select low writes data.
// - serial mode: hold enable and direction pins low permanently.
// - parallel modes move one byte per transfer on eight-bit bus.
// - serial mode: data on bus bit 1, clock on bus bit 0.
// - unused bus pins driven low, except bit 2 during a serial transfer.
// - device responds only while chip select is low.
// - two static select inputs choose the host interface mode.
`timescale 1ns/1ps
module dhb_host (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic init_req_in,
  input wire logic req_valid_in,
  input wire logic req_read_in,
  input wire logic req_is_data_in,
  input wire logic [7:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_rdata_out,
  output logic protocol_select_0_out,
  output logic protocol_select_1_out,
  output logic power_on_init_n_out,
  output logic chip_sel_n_out,
  output logic data_cmd_out,
  output logic enable_or_read_out,
  output logic dir_or_write_out,
  output logic [7:0] host_data_bus_out,
  output logic [7:0] host_data_bus_oe_n_out,
  input wire logic [7:0] host_data_bus_in
);
  typedef enum {
    DHB_IDLE, DHB_INIT, DHB_SETUP, DHB_STROBE, DHB_HOLD, DHB_RECOVER,
    DHB_SER_LO, DHB_SER_HI
  } dhb_state_t;
  typedef struct packed {
    dhb_state_t state;
    dhb_pkg::dhb_mode_t mode;
    logic rd;
    logic [7:0] sh;
    logic [dhb_pkg::BIT_W-1:0] bits;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
    logic ps0;
    logic ps1;
    logic init_n;
    logic cs_n;
    logic dc;
    logic en_rd;
    logic dir_wr;
    logic [7:0] dout;
    logic [7:0] oe_n;
  } dhb_host_st_t;
  dhb_host_st_t st_reg;
  dhb_host_st_t st_next;
  logic tmr_load;
  logic [dhb_pkg::TIMER_W-1:0] tmr_count;
  logic tmr_done;
  dhb_tick u_tick (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );
  function automatic logic [dhb_pkg::TIMER_W-1:0] cyc(input int n);
    cyc = dhb_pkg::TIMER_W'(n);
  endfunction
  // strobe levels that mean "idle" for each mode
  function automatic logic idle_en(input dhb_pkg::dhb_mode_t m);
    idle_en = (m == dhb_pkg::DHB_MODE_SPLIT);
  endfunction
  always_comb begin
    st_next = st_reg;
    tmr_load = 1'b0;
    tmr_count = '0;
    st_next.rvalid = 1'b0;
    st_next.sync1 = host_data_bus_in;
    st_next.sync2 = st_reg.sync1;
    unique case (st_reg.state)
      DHB_IDLE: begin
        st_next.ready = 1'b1;
        if (init_req_in) begin
          st_next.ready = 1'b0;
          st_next.init_n = 1'b0;
          tmr_load = 1'b1;
          tmr_count = cyc(dhb_pkg::CYCLE_CYC);
          st_next.state = DHB_INIT;
        end else if (req_valid_in && st_reg.ready) begin
          st_next.ready = 1'b0;
          st_next.dc = req_is_data_in;
          st_next.cs_n = 1'b0;
          st_next.sh = req_wdata_in;
          st_next.rd = req_read_in &&
            (st_reg.mode != dhb_pkg::DHB_MODE_SERIAL);
          if (st_reg.mode == dhb_pkg::DHB_MODE_SERIAL) begin
            st_next.bits = '0;
            st_next.dout = 8'h00;
            st_next.dout[dhb_pkg::SER_CLK_BIT] = 1'b0;
            st_next.dout[dhb_pkg::SER_DATA_BIT] = req_wdata_in[7];
            st_next.oe_n = 8'h00;
            st_next.oe_n[2] = 1'b1;
            tmr_load = 1'b1;
            tmr_count = cyc(dhb_pkg::SCK_HALF_CYC);
            st_next.state = DHB_SER_LO;
          end else begin
            if (st_reg.mode == dhb_pkg::DHB_MODE_ENABLE) begin
              st_next.dir_wr = req_read_in;
            end
            // release the bus for reads so the device can drive it
            st_next.oe_n = req_read_in ? 8'hFF : 8'h00;
            st_next.dout = req_read_in ? 8'h00 : req_wdata_in;
            tmr_load = 1'b1;
            tmr_count = cyc(dhb_pkg::SETUP_CYC);
            st_next.state = DHB_SETUP;
          end
        end
      end
      DHB_INIT: begin
        if (tmr_done) begin
          st_next.init_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = cyc(dhb_pkg::CYCLE_CYC);
          st_next.state = DHB_RECOVER;
        end
      end
      DHB_SETUP: begin
        if (tmr_done) begin
          if (st_reg.mode == dhb_pkg::DHB_MODE_ENABLE) begin
            st_next.en_rd = 1'b1;
          end else if (st_reg.rd) begin
            st_next.en_rd = 1'b0;
          end else begin
            st_next.dir_wr = 1'b0;
          end
          tmr_load = 1'b1;
          tmr_count = st_reg.rd ? cyc(dhb_pkg::RD_LOW_CYC) :
            cyc(dhb_pkg::WR_LOW_CYC);
          st_next.state = DHB_STROBE;
        end
      end
      DHB_STROBE: begin
        if (tmr_done) begin
          if (st_reg.rd) begin
            st_next.rdata = st_reg.sync2;
            st_next.rvalid = 1'b1;
          end
          st_next.en_rd = idle_en(st_reg.mode);
          if (st_reg.mode == dhb_pkg::DHB_MODE_SPLIT) begin
            st_next.dir_wr = 1'b1;
          end
          tmr_load = 1'b1;
          tmr_count = cyc(dhb_pkg::HOLD_CYC);
          st_next.state = DHB_HOLD;
        end
      end
      DHB_HOLD: begin
        if (tmr_done) begin
          st_next.cs_n = 1'b1;
          st_next.dir_wr = (st_reg.mode == dhb_pkg::DHB_MODE_SPLIT);
          st_next.dout = 8'h00;
          st_next.oe_n = 8'h00;
          tmr_load = 1'b1;
          tmr_count = cyc(dhb_pkg::HIGH_CYC);
          st_next.state = DHB_RECOVER;
        end
      end
      DHB_SER_LO: begin
        if (tmr_done) begin
          st_next.dout[dhb_pkg::SER_CLK_BIT] = 1'b1;
          tmr_load = 1'b1;
          tmr_count = cyc(dhb_pkg::SCK_HALF_CYC);
          st_next.state = DHB_SER_HI;
        end
      end
      DHB_SER_HI: begin
        if (tmr_done) begin
          st_next.dout[dhb_pkg::SER_CLK_BIT] = 1'b0;
          tmr_load = 1'b1;
          if (st_reg.bits == dhb_pkg::BIT_W'(7)) begin
            tmr_count = cyc(dhb_pkg::HOLD_CYC);
            st_next.state = DHB_HOLD;
          end else begin
            st_next.bits = st_reg.bits + dhb_pkg::BIT_W'(1);
            st_next.sh = {st_reg.sh[6:0], 1'b0};
            st_next.dout[dhb_pkg::SER_DATA_BIT] = st_reg.sh[6];
            tmr_count = cyc(dhb_pkg::SCK_HALF_CYC);
            st_next.state = DHB_SER_LO;
          end
        end
      end
      DHB_RECOVER: begin
        if (tmr_done) begin
          st_next.state = DHB_IDLE;
        end
      end
      default: begin
        st_next.state = DHB_IDLE;
      end
    endcase
    if (st_reg.state == DHB_IDLE && !st_next.cs_n == 1'b0) begin
      // mode is only latched between transfers
      unique case (mode_sel_in)
        dhb_pkg::SEL_ENABLE_STROBE: st_next.mode = dhb_pkg::DHB_MODE_ENABLE;
        dhb_pkg::SEL_SPLIT_STROBE: st_next.mode = dhb_pkg::DHB_MODE_SPLIT;
        default: st_next.mode = dhb_pkg::DHB_MODE_SERIAL;
      endcase
      {st_next.ps1, st_next.ps0} = mode_sel_in;
      if (st_next.mode == dhb_pkg::DHB_MODE_SERIAL) begin
        st_next.en_rd = 1'b0;
        st_next.dir_wr = 1'b0;
      end else begin
        st_next.en_rd = idle_en(st_next.mode);
        st_next.dir_wr = idle_en(st_next.mode);
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.state <= DHB_IDLE;
      st_reg.mode <= dhb_pkg::DHB_MODE_SERIAL;
      st_reg.init_n <= 1'b1;
      st_reg.cs_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign req_ready_out = st_reg.ready;
  assign rsp_valid_out = st_reg.rvalid;
  assign rsp_rdata_out = st_reg.rdata;
  assign protocol_select_0_out = st_reg.ps0;
  assign protocol_select_1_out = st_reg.ps1;
  assign power_on_init_n_out = st_reg.init_n;
  assign chip_sel_n_out = st_reg.cs_n;
  assign data_cmd_out = st_reg.dc;
  assign enable_or_read_out = st_reg.en_rd;
  assign dir_or_write_out = st_reg.dir_wr;
  assign host_data_bus_out = st_reg.dout;
  assign host_data_bus_oe_n_out = st_reg.oe_n;

  property p_cs_only_busy;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_reg.en_rd && st_reg.mode == dhb_pkg::DHB_MODE_ENABLE
      |-> !st_reg.cs_n;
  endproperty
  a_cs_only_busy: assert property (p_cs_only_busy)
    else $error("enable high without chip select");
  property p_en_strobe;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(st_reg.en_rd) && st_reg.mode == dhb_pkg::DHB_MODE_ENABLE
      |-> !st_reg.cs_n;
  endproperty
  a_en_strobe: assert property (p_en_strobe)
    else $error("enable strobe without chip select");
  property p_dir;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_reg.en_rd && st_reg.mode == dhb_pkg::DHB_MODE_ENABLE
      |-> st_reg.dir_wr == st_reg.rd;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction pin wrong during enable strobe");
  property p_rd_strobe;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(st_reg.en_rd) && st_reg.mode == dhb_pkg::DHB_MODE_SPLIT
      |-> !st_reg.cs_n && st_reg.rd && st_reg.oe_n == 8'hFF;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("read strobe outside a read");
  property p_wr_strobe;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(st_reg.dir_wr) && st_reg.mode == dhb_pkg::DHB_MODE_SPLIT
      |-> !st_reg.cs_n && !st_reg.rd && st_reg.oe_n == 8'h00;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe)
    else $error("write strobe outside a write");
  property p_serial_low;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_reg.mode == dhb_pkg::DHB_MODE_SERIAL && st_reg.state != DHB_IDLE
      |-> !st_reg.en_rd && !st_reg.dir_wr;
  endproperty
  a_serial_low: assert property (p_serial_low)
    else $error("strobe pins not low in serial mode");
  property p_ser_clk;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(st_reg.dout[0]) && st_reg.mode == dhb_pkg::DHB_MODE_SERIAL
      |-> $stable(st_reg.dout[1]) && !st_reg.cs_n;
  endproperty
  a_ser_clk: assert property (p_ser_clk)
    else $error("serial data moved on clock rise");
  property p_ser_d2;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_reg.mode == dhb_pkg::DHB_MODE_SERIAL && !st_reg.cs_n
      |-> st_reg.oe_n[2] && st_reg.dout[7:2] == 6'h00;
  endproperty
  a_ser_d2: assert property (p_ser_d2)
    else $error("unused bus pins not low in serial mode");
  property p_init;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(st_reg.init_n) |-> !st_reg.init_n [*8];
  endproperty
  a_init: assert property (p_init)
    else $error("reset pulse too short");
  property p_rvalid;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_reg.rvalid |-> st_reg.rd && !st_reg.cs_n;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read answer outside a parallel read");
  c_par_read: cover property (@(posedge ref_clk_in) st_reg.rvalid);
  c_ser_done: cover property (@(posedge ref_clk_in)
    st_reg.state == DHB_SER_HI && st_reg.bits == 3'h7);
  c_split_wr: cover property (@(posedge ref_clk_in)
    $fell(st_reg.dir_wr) && st_reg.mode == dhb_pkg::DHB_MODE_SPLIT);
  c_init: cover property (@(posedge ref_clk_in) $rose(st_reg.init_n));
endmodule

/* dhb_dev_model.sv */
// behavioural display device answering the host bus controller
`timescale 1ns/1ps
module dhb_dev_model #(
  parameter logic [7:0] READ_BYTE = 8'h96
) (
  input wire logic ref_clk_in,
  input wire logic protocol_select_0_in,
  input wire logic protocol_select_1_in,
  input wire logic power_on_init_n_in,
  input wire logic chip_sel_n_in,
  input wire logic data_cmd_in,
  input wire logic enable_or_read_in,
  input wire logic dir_or_write_in,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] acc_cyc_in,
  output logic [7:0] rd_byte_out,
  output logic rd_drive_n_out,
  output logic [7:0] wr_byte_out,
  output logic wr_dc_out,
  output logic [7:0] wr_cnt_out,
  output logic [7:0] init_cnt_out,
  output logic [7:0] viol_cnt_out
);
  logic [1:0] sel;
  logic rd_act, par_wr, en_q, wr_q, sck_q, ini_q;
  logic [7:0] acc, sh;
  logic [3:0] nbit;
  logic en_md, sp_md;
  assign sel = {protocol_select_1_in, protocol_select_0_in};
  assign en_md = sel == dhb_pkg::SEL_ENABLE_STROBE;
  assign sp_md = sel == dhb_pkg::SEL_SPLIT_STROBE;
  // read live only while selected
  assign rd_act = !chip_sel_n_in && ((en_md && enable_or_read_in &&
    dir_or_write_in) || (sp_md && !enable_or_read_in));
  // write completes on strobe release
  assign par_wr = (en_md && en_q && !enable_or_read_in && !dir_or_write_in)
    || (sp_md && !wr_q && dir_or_write_in);
  // bus driven only inside a read, after the access delay
  assign rd_drive_n_out = !(rd_act && acc >= acc_cyc_in);
  assign rd_byte_out = READ_BYTE;
  initial begin
    {acc, sh, nbit, wr_byte_out, wr_dc_out} = '0;
    {wr_cnt_out, init_cnt_out, viol_cnt_out} = '0;
    {en_q, wr_q, sck_q, ini_q} = 4'hF;
  end
  always @(posedge ref_clk_in) begin
    en_q <= enable_or_read_in;
    wr_q <= dir_or_write_in;
    sck_q <= host_data_bus_in[0];
    ini_q <= power_on_init_n_in;
    acc <= rd_act ? acc + 8'h01 : 8'h00;
    if (!power_on_init_n_in) begin
      wr_cnt_out <= 8'h00;
      nbit <= 4'h0;
      if (ini_q) init_cnt_out <= init_cnt_out + 8'h01;
    end else if (chip_sel_n_in) begin
      nbit <= 4'h0;
    end else if (en_md || sp_md) begin
      if (par_wr) begin
        wr_byte_out <= host_data_bus_in;
        wr_dc_out <= data_cmd_in;
        wr_cnt_out <= wr_cnt_out + 8'h01;
      end
    end else begin
      if (enable_or_read_in || dir_or_write_in ||
          host_data_bus_in[7:3] != 5'h00) begin
        viol_cnt_out <= viol_cnt_out + 8'h01;
      end
      if (!sck_q && host_data_bus_in[0]) begin
        sh <= {sh[6:0], host_data_bus_in[1]};
        nbit <= nbit + 4'h1;
        if (nbit == 4'h7) begin
          wr_byte_out <= {sh[6:0], host_data_bus_in[1]};
          wr_dc_out <= data_cmd_in;
          wr_cnt_out <= wr_cnt_out + 8'h01;
          nbit <= 4'h0;
        end
      end
    end
  end
endmodule

/* dhb_host_bench.sv */
// self-checking bench for the display host bus controller
`timescale 1ns/1ps
module dhb_host_bench;
  localparam logic [7:0] RD_VAL = 8'h96;
  logic clk = 0, rst_n = 0, init_req = 0, vld = 0, rd = 0, dc = 0;
  logic [1:0] mode = 2'h3;
  logic [7:0] wd = 8'h00, acc = 8'h02;
  logic [7:0] h_out, oe_n, bus_w, rdata, d_byte, wr_byte, wr_cnt;
  logic [7:0] init_cnt, viol;
  logic rdy, rsp_v, ps0, ps1, init_n, cs_n, dco, en_rd, dir_wr;
  logic d_drv_n, wr_dc;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  dhb_host dhb_host_inst (.ref_clk_in(clk), .rst_n_in(rst_n),
    .mode_sel_in(mode), .init_req_in(init_req), .req_valid_in(vld),
    .req_read_in(rd), .req_is_data_in(dc), .req_wdata_in(wd),
    .req_ready_out(rdy), .rsp_valid_out(rsp_v), .rsp_rdata_out(rdata),
    .protocol_select_0_out(ps0), .protocol_select_1_out(ps1),
    .power_on_init_n_out(init_n), .chip_sel_n_out(cs_n),
    .data_cmd_out(dco), .enable_or_read_out(en_rd),
    .dir_or_write_out(dir_wr), .host_data_bus_out(h_out),
    .host_data_bus_oe_n_out(oe_n), .host_data_bus_in(bus_w));
  dhb_dev_model #(.READ_BYTE(RD_VAL)) dhb_dev_model_inst (
    .ref_clk_in(clk), .protocol_select_0_in(ps0),
    .protocol_select_1_in(ps1), .power_on_init_n_in(init_n),
    .chip_sel_n_in(cs_n), .data_cmd_in(dco), .enable_or_read_in(en_rd),
    .dir_or_write_in(dir_wr), .host_data_bus_in(bus_w),
    .acc_cyc_in(acc), .rd_byte_out(d_byte), .rd_drive_n_out(d_drv_n),
    .wr_byte_out(wr_byte), .wr_dc_out(wr_dc), .wr_cnt_out(wr_cnt),
    .init_cnt_out(init_cnt), .viol_cnt_out(viol));
  // an undriven line i shows cycle count bit i, inverted for odd i, so it changes every 2^i cycles
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_w[i] = !oe_n[i] ? h_out[i] : !d_drv_n ? d_byte[i] :
        cyc[i] ^ i[0];
    end
  end
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic do_req(input logic r, input logic d, input logic [7:0] w,
                        output logic v, output logic [7:0] q);
    v = 0;
    q = 8'h00;
    wait_ready();
    rd = r;
    dc = d;
    wd = w;
    vld = 1;
    @(posedge clk);
    #1;
    vld = 0;
    @(posedge clk);
    #1;
    while (rdy !== 1'b1 && cyc < 20000) begin
      if (rsp_v === 1'b1) begin
        v = 1;
        q = rdata;
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_write(input logic [1:0] m, input logic d,
                         input logic [7:0] w);
    logic v;
    logic [7:0] q, c0;
    mode = m;
    @(posedge clk);
    #1;
    chk("select pins", {6'h00, m}, {6'h00, ps1, ps0});
    c0 = wr_cnt;
    do_req(1'b0, d, w, v, q);
    chk("write byte", w, wr_byte);
    chk("write dc", {7'h00, d}, {7'h00, wr_dc});
    chk("write count", c0 + 8'h01, wr_cnt);
    $display("write test mode %h byte %h done", m, w);
  endtask
  task automatic t_read(input logic [1:0] m, input logic [7:0] a);
    logic v;
    logic [7:0] q, c0;
    mode = m;
    acc = a;
    @(posedge clk);
    #1;
    c0 = wr_cnt;
    do_req(1'b1, 1'b1, 8'h00, v, q);
    chk("read valid", 8'h01, {7'h00, v});
    chk("read byte", RD_VAL, q);
    chk("no write on read", c0, wr_cnt);
    $display("read test mode %h delay %0d done", m, a);
  endtask
  task automatic t_init();
    logic [7:0] c0;
    int n;
    c0 = init_cnt;
    wait_ready();
    init_req = 1;
    n = 0;
    while (init_n !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    init_req = 0;
    wait_ready();
    chk("init pulses", c0 + 8'h01, init_cnt);
    chk("init released", 8'h01, {7'h00, init_n});
    chk("count cleared", 8'h00, wr_cnt);
    $display("init test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    t_write(dhb_pkg::SEL_ENABLE_STROBE, 1'b0, 8'hA5);
    t_write(dhb_pkg::SEL_ENABLE_STROBE, 1'b1, 8'h3C);
    t_write(dhb_pkg::SEL_SPLIT_STROBE, 1'b1, 8'h81);
    t_write(dhb_pkg::SEL_SPLIT_STROBE, 1'b0, 8'h7E);
    t_write(dhb_pkg::SEL_SERIAL, 1'b1, 8'hB4);
    t_write(dhb_pkg::SEL_SERIAL, 1'b0, 8'h01);
    t_read(dhb_pkg::SEL_ENABLE_STROBE, 8'h02);
    t_read(dhb_pkg::SEL_SPLIT_STROBE, 8'h22);
    t_read(dhb_pkg::SEL_ENABLE_STROBE, 8'h22);
    t_init();
    t_write(dhb_pkg::SEL_SPLIT_STROBE, 1'b1, 8'hC6);
    chk("serial pin faults", 8'h00, viol);
    end_of_test();
  end
endmodule
